// ==== logic/pattern_trigger_time_qualifier.v ====
//
// Operation
// (RULE1) after holdoff, watch sixteen channels plus auxiliary input as pattern sources
// (RULE2) each input expects high, low or ignore; ignored inputs never count
// (RULE3) and: true only when every considered input matches
// (RULE4) nand: true when any considered input mismatches
// (RULE5) or: true when any considered input matches
// (RULE6) nor: true only when every considered input mismatches
// (RULE7) duration timer starts the moment the combined pattern goes true
// (RULE8) pattern going true alone never triggers; only qualification does
// (RULE9) all qualifiers but timeout wait for the pattern to go false
// (RULE10) at the false edge, trigger if measured duration qualifies, else nothing
// (RULE11) longer: duration above limit qualifies; shorter: below limit qualifies
// (RULE12) timeout: trigger the instant the limit elapses while still true
// (RULE13) inside window: ends after minimum and before maximum, trigger on false
// (RULE14) outside window: ends before minimum or after maximum, trigger on false
// (RULE15) no trigger when every input is ignored
// (RULE16) smallest duration qualification is about two ns, used with timeout; here it is one clock, 25 ns at 40 MHz
// (RULE17) inputs sampled each clock, limits in cycles, timer saturates
// (RULE18) trigger is a one-cycle pulse; timer clears when false or in holdoff
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pattern_trigger_regs.vh"

module pattern_trigger_time_qualifier #(
    parameter NUM_CH = 16,
    parameter TIMER_W = 24
) (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // probed inputs from the pins
    input wire [NUM_CH-1:0] ch_in,
    input wire aux_in,
    // acquisition control, same clock
    input wire holdoff_active,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // trigger and status outputs
    output reg trig_out,
    output reg pattern_true,
    output wire irq
);

localparam NUM_IN = NUM_CH + 1;
localparam [TIMER_W-1:0] TIMER_MAX = {TIMER_W{1'b1}};
localparam integer MIN_CYC_I = `MIN_QUAL_CYC;
localparam [TIMER_W-1:0] MIN_CYC = MIN_CYC_I[TIMER_W-1:0];

// reset words cut to the pattern width on purpose
localparam [31:0] LEVEL_RST_W = `LEVEL_RST;
localparam [31:0] CARE_RST_W = `CARE_RST;
localparam [NUM_IN-1:0] LEVEL_RST_V = LEVEL_RST_W[NUM_IN-1:0];
localparam [NUM_IN-1:0] CARE_RST_V = CARE_RST_W[NUM_IN-1:0];

// qualifier states
localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_TIMING = 2'd1;
localparam [1:0] ST_EXPIRED = 2'd2;

////////////////////////////////////////////////////////////////////////////////
// limits never drop below the smallest settable qualification
function [TIMER_W-1:0] clamp_limit;
    input [31:0] raw;
    begin
        if (raw[TIMER_W-1:0] < MIN_CYC)
            clamp_limit = MIN_CYC; // see (RULE16)
        else
            clamp_limit = raw[TIMER_W-1:0];
    end
endfunction

// one address compare shared by every register write decode
function reg_hit;
    input [3:0] addr;
    input [3:0] idx;
    begin
        reg_hit = (addr == idx);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// configuration registers
reg [31:0] ctrl;
reg [NUM_IN-1:0] level;
reg [NUM_IN-1:0] care;
reg [TIMER_W-1:0] limit;
reg [TIMER_W-1:0] wmax;
reg [1:0] status;
reg [1:0] mask;
reg [15:0] trig_count;

wire enable;
wire [1:0] func;
wire [2:0] qual;
wire hit_ctrl;
wire hit_level;
wire hit_care;
wire hit_limit;
wire hit_wmax;
wire hit_status;
wire hit_mask;

assign enable = ctrl[`CTRL_EN];
assign func = ctrl[`CTRL_FUNC_HI:`CTRL_FUNC_LO];
assign qual = ctrl[`CTRL_QUAL_HI:`CTRL_QUAL_LO];
assign hit_ctrl = reg_wr && reg_hit(reg_addr, `REG_CTRL);
assign hit_level = reg_wr && reg_hit(reg_addr, `REG_LEVEL);
assign hit_care = reg_wr && reg_hit(reg_addr, `REG_CARE);
assign hit_limit = reg_wr && reg_hit(reg_addr, `REG_LIMIT);
assign hit_wmax = reg_wr && reg_hit(reg_addr, `REG_WMAX);
assign hit_status = reg_wr && reg_hit(reg_addr, `REG_STATUS);
assign hit_mask = reg_wr && reg_hit(reg_addr, `REG_MASK);

////////////////////////////////////////////////////////////////////////////////
// input sampling and pattern combination
wire [NUM_IN-1:0] in_level;
wire pat_now;

pin_sync #(
    .WIDTH(NUM_IN)
) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in({aux_in, ch_in}), // see (RULE1)
    .level_out(in_level)
);

pattern_compare #(
    .WIDTH(NUM_IN)
) u_compare (
    .inputs(in_level),
    .level(level),
    .care(care),
    .func(func),
    .pattern(pat_now)
);

////////////////////////////////////////////////////////////////////////////////
// evaluation runs only when enabled and outside holdoff
wire run;
wire pat_live;
reg pat_q;
wire pat_fall;

assign run = enable && !holdoff_active; // see (RULE1)
assign pat_live = pat_now && run;
// a drop caused by holdoff is not a real false edge
assign pat_fall = pat_q && !pat_now && run; // see (RULE9)

////////////////////////////////////////////////////////////////////////////////
// duration timer: counts true cycles, holds at the top value
reg [TIMER_W-1:0] timer;
reg [TIMER_W-1:0] next_timer;

always @* begin
    next_timer = timer;
    if (!pat_live)
        next_timer = {TIMER_W{1'b0}}; // see (RULE18)
    else if (timer != TIMER_MAX)
        next_timer = timer + {{(TIMER_W-1){1'b0}}, 1'b1}; // see (RULE7) (RULE17)
end

always @(posedge sys_clk) begin
    if (!rstn) begin
        timer <= {TIMER_W{1'b0}};
        pat_q <= 1'b0;
    end else begin
        timer <= next_timer;
        pat_q <= pat_live;
    end
end

////////////////////////////////////////////////////////////////////////////////
// qualification decision at the false edge
// timer still holds the number of true cycles in the fall cycle
reg fall_ok;

always @* begin
    fall_ok = 1'b0;
    case (qual)
        `QUAL_LESS: fall_ok = (timer < limit); // see (RULE11)
        `QUAL_GREATER: fall_ok = (timer > limit); // see (RULE11)
        `QUAL_IN_WINDOW: fall_ok = (timer > limit) && (timer < wmax); // see (RULE13)
        `QUAL_OUTSIDE_WINDOW: fall_ok = (timer < limit) || (timer > wmax); // see (RULE14)
        default: fall_ok = 1'b0; // timeout never decides at the fall
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// timeout fires once per true period, when the count first reaches the limit
wire timeout_hit;

assign timeout_hit = (qual == `QUAL_TIMEOUT) && pat_live
                     && (next_timer == limit) && (timer != limit); // see (RULE12)

////////////////////////////////////////////////////////////////////////////////
// qualifier state machine, mainly for readback and for sequencing clarity
reg [1:0] qstate;
reg [1:0] next_qstate;
reg fire;

always @* begin
    next_qstate = qstate;
    fire = 1'b0;
    case (qstate)
        ST_IDLE: begin
            // going true only starts the timer; only a timeout with a limit of one fires here
            if (pat_live) begin // see (RULE8)
                next_qstate = ST_TIMING;
                fire = timeout_hit;
                if (timeout_hit)
                    next_qstate = ST_EXPIRED;
            end
        end
        ST_TIMING: begin
            if (!pat_live) begin
                next_qstate = ST_IDLE;
                fire = pat_fall && fall_ok; // see (RULE10)
            end else if (timeout_hit) begin
                next_qstate = ST_EXPIRED;
                fire = 1'b1; // see (RULE12)
            end
        end
        ST_EXPIRED: begin
            // timeout already fired; wait for the pattern to end
            if (!pat_live)
                next_qstate = ST_IDLE;
        end
        default: next_qstate = ST_IDLE;
    endcase
end

// the trigger is a registered one-cycle pulse
always @(posedge sys_clk) begin
    if (!rstn) begin
        qstate <= ST_IDLE;
        trig_out <= 1'b0;
        pattern_true <= 1'b0;
    end else begin
        qstate <= next_qstate;
        trig_out <= fire; // see (RULE18)
        pattern_true <= pat_live;
    end
end

////////////////////////////////////////////////////////////////////////////////
// events for the interrupt status
wire [1:0] events;
wire sat_event;

assign sat_event = pat_live && (timer != TIMER_MAX) && (next_timer == TIMER_MAX);
assign events = {sat_event, fire};

////////////////////////////////////////////////////////////////////////////////
// control word; unmapped writes match no decode and leave no trace
always @(posedge sys_clk) begin
    if (!rstn)
        ctrl <= `CTRL_RST;
    else if (hit_ctrl)
        ctrl <= reg_wdata;
end

// pattern setup: expected level and considered inputs
always @(posedge sys_clk) begin
    if (!rstn) begin
        level <= LEVEL_RST_V;
        care <= CARE_RST_V;
    end else begin
        if (hit_level)
            level <= reg_wdata[NUM_IN-1:0]; // see (RULE2)
        if (hit_care)
            care <= reg_wdata[NUM_IN-1:0]; // see (RULE2)
    end
end

// time limits in cycles; a zero is raised to the shortest qualification
always @(posedge sys_clk) begin
    if (!rstn) begin
        limit <= clamp_limit(`LIMIT_RST);
        wmax <= clamp_limit(`WMAX_RST);
    end else begin
        if (hit_limit)
            limit <= clamp_limit(reg_wdata); // see (RULE17)
        if (hit_wmax)
            wmax <= clamp_limit(reg_wdata); // see (RULE17)
    end
end

// interrupt mask, same layout as the status word
always @(posedge sys_clk) begin
    if (!rstn)
        mask <= 2'b00;
    else if (hit_mask)
        mask <= reg_wdata[1:0];
end

// sticky status: set has priority over the clear in the same cycle
always @(posedge sys_clk) begin
    if (!rstn)
        status <= 2'b00;
    else if (hit_status)
        status <= (status & ~reg_wdata[1:0]) | events;
    else
        status <= status | events;
end

// trigger counter wraps; software reads differences
always @(posedge sys_clk) begin
    if (!rstn)
        trig_count <= 16'h0000;
    else if (hit_ctrl)
        trig_count <= 16'h0000; // any control write restarts the count
    else if (fire)
        trig_count <= trig_count + 16'h0001;
end

assign irq = |(status & mask);

////////////////////////////////////////////////////////////////////////////////
// readback: data stand only in the cycle after the read strobe
reg [31:0] rd_mux;

always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
        `REG_CTRL: rd_mux = ctrl;
        `REG_LEVEL: rd_mux[NUM_IN-1:0] = level;
        `REG_CARE: rd_mux[NUM_IN-1:0] = care;
        `REG_LIMIT: rd_mux[TIMER_W-1:0] = limit;
        `REG_WMAX: rd_mux[TIMER_W-1:0] = wmax;
        `REG_STATUS: rd_mux[1:0] = status;
        `REG_MASK: rd_mux[1:0] = mask;
        `REG_STATE: rd_mux = {trig_count, 12'h000, qstate, pat_live, run};
        `REG_TIMER: rd_mux[TIMER_W-1:0] = timer;
        default: rd_mux = 32'h0000_0000; // unmapped reads as zero
    endcase
end

always @(posedge sys_clk) begin
    if (!rstn)
        reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
        reg_rdata <= rd_mux;
    else
        reg_rdata <= 32'h0000_0000;
end

endmodule // pattern_trigger_time_qualifier
`default_nettype wire

// ==== logic/pattern_trigger_regs.vh ====
`ifndef PATTERN_TRIGGER_REGS_VH
`define PATTERN_TRIGGER_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register word indices on the plain register port
`define REG_CTRL 4'h0
`define REG_LEVEL 4'h1
`define REG_CARE 4'h2
`define REG_LIMIT 4'h3
`define REG_WMAX 4'h4
`define REG_STATUS 4'h5
`define REG_MASK 4'h6
`define REG_STATE 4'h7
`define REG_TIMER 4'h8

////////////////////////////////////////////////////////////////////////////////
// control word fields
`define CTRL_EN 0
`define CTRL_FUNC_LO 1
`define CTRL_FUNC_HI 2
`define CTRL_QUAL_LO 4
`define CTRL_QUAL_HI 6

// boolean functions
`define FUNC_AND 2'h0
`define FUNC_NAND 2'h1
`define FUNC_OR 2'h2
`define FUNC_NOR 2'h3

// time qualifiers
`define QUAL_LESS 3'h0
`define QUAL_GREATER 3'h1
`define QUAL_TIMEOUT 3'h2
`define QUAL_IN_WINDOW 3'h3
`define QUAL_OUTSIDE_WINDOW 3'h4

// status and mask bits
`define ST_TRIG 0
`define ST_SAT 1

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CTRL_RST 32'h0000_0000
`define LEVEL_RST 32'h0000_0000
`define CARE_RST 32'h0000_0000
`define LIMIT_RST 32'h0000_0001
`define WMAX_RST 32'h0000_0002

////////////////////////////////////////////////////////////////////////////////
// timing: smallest duration qualification, in ns, and the clock in MHz
`define MIN_QUAL_NS 2
`define CLK_MHZ 40
`define MIN_QUAL_RAW ((`MIN_QUAL_NS * `CLK_MHZ + 999) / 1000)
`define MIN_QUAL_CYC ((`MIN_QUAL_RAW < 1) ? 1 : `MIN_QUAL_RAW)

`endif

// ==== logic/pin_sync.v ====
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser; a bit changes once stages two and three agree
module pin_sync #(
    parameter WIDTH = 17
) (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // asynchronous pins in, clean levels out
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_out
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

////////////////////////////////////////////////////////////////////////////////
// stage1 feeds stage2 only, so no logic sees a metastable value
always @(posedge sys_clk) begin
    if (!rstn) begin
        stage1 <= {WIDTH{1'b0}};
        stage2 <= {WIDTH{1'b0}};
        stage3 <= {WIDTH{1'b0}};
        level_out <= {WIDTH{1'b0}};
    end else begin
        stage1 <= pin_in;
        stage2 <= stage1;
        stage3 <= stage2;
        level_out <= (stage2 & stage3) | (level_out & (stage2 | stage3)); // see (RULE17)
    end
end

endmodule // pin_sync
`default_nettype wire

// ==== logic/pattern_compare.v ====
`timescale 1ns/100ps
`default_nettype none
`include "pattern_trigger_regs.vh"

// combines the per-input compare with the selected boolean function
module pattern_compare #(
    parameter WIDTH = 17
) (
    // sampled inputs and pattern setup
    input wire [WIDTH-1:0] inputs,
    input wire [WIDTH-1:0] level,
    input wire [WIDTH-1:0] care,
    input wire [1:0] func,
    // combined result
    output reg pattern
);

wire [WIDTH-1:0] match;
wire [WIDTH-1:0] differ;
wire any_care;

// ignored inputs count neither as a match nor as a miss
assign match = ~(inputs ^ level) & care; // see (RULE2)
assign differ = (inputs ^ level) & care;
assign any_care = |care;

////////////////////////////////////////////////////////////////////////////////
// all-ignore never recognises a pattern, whatever the function
always @* begin
    pattern = 1'b0;
    if (any_care) begin // see (RULE15)
        case (func)
            `FUNC_AND: pattern = ~|differ; // see (RULE3)
            `FUNC_NAND: pattern = |differ; // see (RULE4)
            `FUNC_OR: pattern = |match; // see (RULE5)
            `FUNC_NOR: pattern = ~|match; // see (RULE6)
            default: pattern = 1'b0;
        endcase
    end
end

endmodule // pattern_compare
`default_nettype wire

// ==== dv/pattern_trigger_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pattern_trigger_regs.vh"

module pattern_trigger_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // inputs watched
    input wire logic holdoff_active,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // outputs watched
    input wire logic trig_out,
    input wire logic pattern_true
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////
    // shadow of the setup; run counts true cycles before now
    logic [2:0] q;
    logic [23:0] lim, wmax, run;
    logic nocare;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q <= 3'h0;
            lim <= 24'h1;
            wmax <= 24'h2;
            nocare <= 1'b1;
            run <= 24'h0;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL) q <= reg_wdata[6:4];
            if (reg_wr && reg_addr == `REG_LIMIT) lim <= reg_wdata[23:0];
            if (reg_wr && reg_addr == `REG_WMAX) wmax <= reg_wdata[23:0];
            if (reg_wr && reg_addr == `REG_CARE) nocare <= reg_wdata[16:0] == 17'h0;
            run <= pattern_true ? run + 24'h1 : 24'h0;
        end
    end

    ////////////////////////////////////////
    // a true period ending by itself; a holdoff cut must not count
    sequence s_end;
        pattern_true && !holdoff_active ##1 !pattern_true;
    endsequence

    AST_PULSE: assert property (trig_out |=> !trig_out)
        else $error("trigger wider than one cycle");
    AST_ON_FALL: assert property (trig_out && q != `QUAL_TIMEOUT |-> $fell(pattern_true))
        else $error("trigger away from the false edge");
    AST_NOT_RISE: assert property ($rose(pattern_true) && q != `QUAL_TIMEOUT |-> !trig_out)
        else $error("trigger as the pattern went true");
    AST_LESS: assert property (trig_out && q == `QUAL_LESS |-> run < lim)
        else $error("shorter qualifier fired on a long period");
    AST_GREATER: assert property (q == `QUAL_GREATER && run > lim ##0 s_end |-> trig_out)
        else $error("long period ended without trigger");
    AST_TIMEOUT: assert property (trig_out && q == `QUAL_TIMEOUT |-> pattern_true && run == lim - 24'h1)
        else $error("timeout fired at the wrong count");
    AST_QUICK: assert property (q == `QUAL_TIMEOUT && lim == 24'h1 && $rose(pattern_true) |-> trig_out)
        else $error("shortest timeout did not fire at once");
    AST_IN_WIN: assert property (trig_out && q == `QUAL_IN_WINDOW |-> run > lim && run < wmax)
        else $error("window trigger outside the window");
    AST_OUT_WIN: assert property (trig_out && q == `QUAL_OUTSIDE_WINDOW |-> run < lim || run > wmax)
        else $error("outside trigger inside the window");
    AST_NO_CARE: assert property (nocare && $past(nocare) |-> !pattern_true)
        else $error("pattern true with every input ignored");
endmodule // pattern_trigger_chk

bind pattern_trigger_time_qualifier pattern_trigger_chk u_pattern_trigger_chk (
    .sys_clk(sys_clk), .rstn(rstn), .holdoff_active(holdoff_active),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .trig_out(trig_out), .pattern_true(pattern_true)
);

`default_nettype wire

// ==== dv/probe_source.sv ====
`timescale 1ns/100ps
`default_nettype none

module probe_source (
    // clock
    input wire logic sys_clk,
    // levels asked for by the bench
    input wire logic [16:0] want,
    input wire logic hold_req,
    // pins of the block
    output logic [15:0] ch_in,
    output logic aux_in,
    output logic holdoff_active
);
    // known levels from time zero
    initial begin
        ch_in = 16'h0;
        aux_in = 1'b0;
        holdoff_active = 1'b0;
    end
    // probes move mid-cycle, as a real pin would; holdoff is same-clock
    always @(posedge sys_clk) begin
        {aux_in, ch_in} <= #7 want;
        holdoff_active <= hold_req;
    end
endmodule // probe_source

`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pattern_trigger_regs.vh"

module testbench;
    localparam int TW = 8;
    logic sys_clk, rstn, hold_req, reg_wr, reg_rd, p;
    logic rd_seen = 1'b0;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [31:0] eq[$], mq[$];
    logic [16:0] want, vin, mt;
    logic [15:0] ch_in, seed;
    logic aux_in, holdoff_active, trig_out, pattern_true, irq;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int n_trig = 0;
    int t0 = 0;
    // qualifier cases: qualifier, true length, trigger expected per bit
    logic [2:0] tq[15] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3,
                           3'h4, 3'h4, 3'h4, 3'h4, 3'h2, 3'h5};
    int tn[15] = '{3, 4, 5, 4, 4, 3, 5, 8, 4, 3, 9, 6, 8, 2, 6};
    logic [14:0] te = 15'h2655;
    logic [3:0] ra[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    logic [31:0] rv[8] = '{`CTRL_RST, `LEVEL_RST, `CARE_RST, `LIMIT_RST, `WMAX_RST,
                           32'h0, 32'h0, 32'h0};

    pattern_trigger_time_qualifier #(.NUM_CH(16), .TIMER_W(TW))
        u_pattern_trigger_time_qualifier (
        .sys_clk(sys_clk), .rstn(rstn), .ch_in(ch_in), .aux_in(aux_in),
        .holdoff_active(holdoff_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trig_out(trig_out), .pattern_true(pattern_true), .irq(irq));

    probe_source u_probe_source (.sys_clk(sys_clk), .want(want), .hold_req(hold_req),
        .ch_in(ch_in), .aux_in(aux_in), .holdoff_active(holdoff_active));

    ////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("compared %0d, mismatched %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // the note of what the read must return goes out with the request
    task rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
        eq.push_back(exp);
        mq.push_back(msk);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask

    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function logic [31:0] ctrl(input logic [2:0] q, input logic [1:0] f);
        return {25'h0, q, 1'b0, f, 1'b1};
    endfunction

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_seen) check(reg_rdata & mq.pop_front(), eq.pop_front());
        rd_seen <= reg_rd;
    end

    // every trigger pulse, taken at the edge after it was launched
    always @(posedge sys_clk) begin
        if (trig_out) n_trig++;
    end

    // hang guard, far beyond the roughly 1200 cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        rstn = 1'b0;
        hold_req = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        want = 17'h0;
        seed = 16'h001b;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        // an unmapped write must leave no trace
        wr(4'h9, 32'hffff_ffff);
        foreach (ra[i]) rd(ra[i], rv[i], 32'hffff_ffff);
        $display("test reset values done");
        // random levels on the ignored pins must not matter
        wr(`REG_CARE, 32'h0001_0003);
        wr(`REG_LEVEL, 32'h0000_0001);
        for (int f = 0; f < 4; f++) begin
            wr(`REG_CTRL, ctrl(3'h7, f[1:0]));
            for (int k = 0; k < 8; k++) begin
                seed = lfsr(seed);
                vin = (k == 0) ? 17'h0_0001 : (k == 1) ? 17'h1_0002 : {seed[15], seed};
                want <= vin;
                repeat (8) @(posedge sys_clk);
                mt = ~(vin ^ 17'h0_0001) & 17'h1_0003;
                p = (f == 0) ? mt == 17'h1_0003 : (f == 1) ? mt != 17'h1_0003 :
                    (f == 2) ? mt != 17'h0 : mt == 17'h0;
                rd(`REG_STATE, {30'h0, p, 1'b0}, 32'h2);
            end
        end
        wr(`REG_CARE, 32'h0);
        wr(`REG_CTRL, ctrl(3'h7, `FUNC_AND));
        want <= 17'h1_ffff;
        repeat (8) @(posedge sys_clk);
        rd(`REG_STATE, 32'h0, 32'h2);
        wr(`REG_CARE, 32'h0000_0001);
        hold_req <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(`REG_STATE, 32'h0, 32'h2);
        rd(`REG_TIMER, 32'h0, 32'h00ff_ffff);
        hold_req <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(`REG_STATE, 32'h2, 32'h2);
        $display("test pattern logic done");
        // each qualifier on both sides of its bounds, interrupt masked on even cases
        want <= 17'h0;
        for (int i = 0; i < 15; i++) begin
            wr(`REG_LIMIT, (i == 13) ? 32'h1 : 32'h4);
            wr(`REG_WMAX, 32'h8);
            wr(`REG_MASK, {31'h0, i[0]});
            wr(`REG_STATUS, 32'h3);
            wr(`REG_CTRL, ctrl(tq[i], `FUNC_AND));
            t0 = n_trig;
            @(posedge sys_clk);
            want <= 17'h1;
            repeat (tn[i]) @(posedge sys_clk);
            want <= 17'h0;
            repeat (12) @(posedge sys_clk);
            rd(`REG_STATUS, {31'h0, te[i]}, 32'h1);
            @(negedge sys_clk);
            check({31'h0, irq}, {31'h0, te[i] & i[0]});
            check(n_trig - t0, {31'h0, te[i]});
            wr(`REG_STATUS, 32'h3);
            @(negedge sys_clk);
            check({31'h0, irq}, 32'h0);
        end
        $display("test qualifiers done");
        // a period far past the timer top; the count must stick there
        wr(`REG_CTRL, ctrl(`QUAL_GREATER, `FUNC_AND));
        want <= 17'h1;
        repeat (300) @(posedge sys_clk);
        rd(`REG_TIMER, (32'h1 << TW) - 32'h1, 32'h00ff_ffff);
        rd(`REG_STATUS, 32'h2, 32'h2);
        want <= 17'h0;
        repeat (12) @(posedge sys_clk);
        rd(`REG_STATUS, 32'h1, 32'h1);
        rd(`REG_TIMER, 32'h0, 32'h00ff_ffff);
        repeat (3) @(posedge sys_clk);
        $display("test saturation done");
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
